// ### fecs_map.svh
// Address map, field positions, command codes and geometry of the flash sequencer
`ifndef FECS_MAP_SVH
`define FECS_MAP_SVH
// ==========================================================================
// Array geometry
`define FECS_PAGES 128
`define FECS_ROWS 8
`define FECS_WORDS_PER_ROW 64
`define FECS_PAGE_WORDS 17'h00200
`define FECS_ALL_WORDS 17'h10000
`define FECS_LAST_WORD 16'hFFFF
`define FECS_LOCK_WORD0 16'hFFFE
`define FECS_LOCK_WORD1 16'hFFFF
`define FECS_ERASED 32'hFFFFFFFF
// Words the engine handles per cycle in erase, fill and check; sizes are multiples of it
`define FECS_LANES 8
`define FECS_BULK_STEP 17'h00008
// ==========================================================================
// Bus decode: this address bit selects the register bank, else the array
`define FECS_REG_SEL_BIT 28
// ==========================================================================
// Register offsets
`define FECS_OFF_COMMAND 8'h00
`define FECS_OFF_MASKED_IRQ_STATUS 8'h08
`define FECS_OFF_IRQMASK 8'h0C
`define FECS_OFF_IRQRAW 8'h10
`define FECS_OFF_SIZE 8'h14
`define FECS_OFF_ADDRESS 8'h18
`define FECS_OFF_SIGNATURE 8'h24
`define FECS_OFF_BURST_WORD_ZERO 8'h40
`define FECS_OFF_DATA1 8'h44
`define FECS_OFF_DATA2 8'h48
`define FECS_OFF_DATA3 8'h4C
// ==========================================================================
// Status flag positions, reset values and signature polynomial
`define FECS_F_DONE 0
`define FECS_F_START 1
`define FECS_F_BUSYERR 2
`define FECS_F_UNKNOWN 3
`define FECS_F_PASS 4
`define FECS_MASK_RST 5'h1F
`define FECS_SIG_SEED 32'hFFFFFFFF
`define FECS_SIG_POLY 32'h8000001B
// ==========================================================================
// Command codes
`define FECS_CMD_PAGE_ERASE 8'h11
`define FECS_CMD_CLEAR_ALL 8'h22
`define FECS_CMD_PROGRAM 8'h33
`define FECS_CMD_FILL_ALL 8'h44
`define FECS_CMD_CHECK_ALL 8'h55
`define FECS_CMD_MULTI 8'hCC
// ==========================================================================
// Host command port
`define FECS_H_ADDR 8'h00
`define FECS_H_WDATA 8'h04
`define FECS_H_CTRL 8'h08
`define FECS_H_STAT 8'h0C
`define FECS_H_RDATA 8'h10
`define FECS_H_GO 0
`define FECS_H_WRITE 1
`define FECS_H_DEBUG 2
`define FECS_H_BUSY 0
`define FECS_H_ERR 1
`define FECS_H_DONE 2
`define FECS_HTRANS_IDLE 2'h0
`define FECS_HTRANS_NONSEQ 2'h2
`define FECS_HSIZE_WORD 3'h2
`endif

// ### fecs_pkg.sv
// Types shared by both ends of the flash sequencer
package fecs_pkg;
  typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} fecs_eng_e;
  typedef enum logic [1:0] {HST_IDLE, HST_ADDR, HST_DATA} fecs_hst_e;

  typedef struct packed {
    fecs_eng_e st;
    logic [7:0] cmd;
    logic [15:0] ptr;
    logic [3:0][31:0] data;
    logic [15:0] cur;
    logic [16:0] left;
    logic [1:0] bidx;
    logic [4:0] raw;
    logic [4:0] mask;
    logic [31:0] sig;
    logic pass;
    logic lock;
    logic dp_valid;
    logic dp_write;
    logic dp_reg;
    logic [7:0] dp_off;
    logic err_a;
    logic err_b;
    logic [31:0] rdata;
  } fecs_dev_s;

  typedef struct packed {
    fecs_hst_e st;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic dbg;
    logic err;
    logic done;
    logic [31:0] bus_rdata;
    logic [31:0] rdata;
  } fecs_host_s;
endpackage

// ### fecs_bus_if.sv
// Word bus between the processor side and the flash sequencer
`timescale 1ns/10ps
interface fecs_bus_if;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic dbg_access;
  logic cpu_halted;
  logic ram_dbg_block;

  modport dev (
    input hsel, haddr, htrans, hwrite, hsize, hwdata, dbg_access, cpu_halted,
    output hrdata, hready, hresp, ram_dbg_block
  );
  modport host (
    output hsel, haddr, htrans, hwrite, hsize, hwdata, dbg_access, cpu_halted,
    input hrdata, hready, hresp, ram_dbg_block
  );
endinterface

// ### fecs_host.sv
// Processor-side master: turns command-port orders into single bus transfers
`timescale 1ns/10ps
`include "fecs_map.svh"
module fecs_host (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_cpu_halted,
  output logic o_ram_dbg_blocked,
  fecs_bus_if.host bus
);
  fecs_pkg::fecs_host_s s_r;
  fecs_pkg::fecs_host_s s_nxt;

  // ==========================================================================
  // Bus drive
  assign bus.hsel = (s_r.st == fecs_pkg::HST_ADDR);
  assign bus.htrans = (s_r.st == fecs_pkg::HST_ADDR) ? `FECS_HTRANS_NONSEQ : `FECS_HTRANS_IDLE;
  assign bus.haddr = s_r.addr;
  assign bus.hwrite = s_r.write;
  assign bus.hsize = `FECS_HSIZE_WORD;
  assign bus.hwdata = s_r.wdata;
  assign bus.dbg_access = s_r.dbg;
  assign bus.cpu_halted = i_cpu_halted;
  assign o_ram_dbg_blocked = bus.ram_dbg_block;
  assign o_rdata = s_r.rdata;

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h00000000;
    if (i_wr && i_addr == `FECS_H_STAT && i_wdata[`FECS_H_DONE]) begin
      s_nxt.done = 1'b0;
    end
    case (s_r.st)
      fecs_pkg::HST_IDLE: begin
        if (i_wr && i_addr == `FECS_H_ADDR) begin
          s_nxt.addr = i_wdata;
        end
        if (i_wr && i_addr == `FECS_H_WDATA) begin
          s_nxt.wdata = i_wdata;
        end
        if (i_wr && i_addr == `FECS_H_CTRL && i_wdata[`FECS_H_GO]) begin
          s_nxt.write = i_wdata[`FECS_H_WRITE];
          s_nxt.dbg = i_wdata[`FECS_H_DEBUG];
          s_nxt.st = fecs_pkg::HST_ADDR;
        end
      end
      fecs_pkg::HST_ADDR: begin
        if (bus.hready) begin
          s_nxt.st = fecs_pkg::HST_DATA;
        end
      end
      fecs_pkg::HST_DATA: begin
        if (bus.hready) begin
          s_nxt.bus_rdata = bus.hrdata;
          s_nxt.err = bus.hresp;
          // Completion wins over a clear in the same cycle
          s_nxt.done = 1'b1;
          s_nxt.st = fecs_pkg::HST_IDLE;
        end
      end
      default: s_nxt.st = fecs_pkg::HST_IDLE;
    endcase
    if (i_rd) begin
      case (i_addr)
        `FECS_H_ADDR: s_nxt.rdata = s_r.addr;
        `FECS_H_WDATA: s_nxt.rdata = s_r.wdata;
        `FECS_H_STAT: begin
          s_nxt.rdata[`FECS_H_BUSY] = (s_r.st != fecs_pkg::HST_IDLE);
          s_nxt.rdata[`FECS_H_ERR] = s_r.err;
          s_nxt.rdata[`FECS_H_DONE] = s_r.done;
        end
        `FECS_H_RDATA: s_nxt.rdata = s_r.bus_rdata;
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ### fecs_dev.sv
// Embedded flash array with its command sequencer, bus slave and readout lock
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "fecs_map.svh"
// Functional notes
// [R1] Array is 128 pages x 8 rows x 64 words
// [R2] Pointer: page 15:9, row 8:6, word 5:0
// [R3] Programming only clears bits; erase sets them
// [R4] Software programs a word at most twice
// [R5] Single word reads served directly on bus
// [R6] Check-all compares every word, sets pass flag
// [R7] Check-all builds 32-bit LFSR signature
// [R8] Accepted flag at start, complete flag at end
// [R9] Writing one clears a pending status flag
// [R10] Page erase sets every bit of page
// [R11] Full clear sets every array bit to one
// [R12] Single program writes data word at pointer
// [R13] Multi-word program writes up to four words
// [R14] Software loads all-ones into unused burst words
// [R15] Fill-all programs every word with data
// [R16] Locked and halted: zero data, debug error
// [R17] Lock also blocks debugger RAM access
// [R18] Lock set unless last two words all-ones
// [R19] Command while busy raises busy error
// [R20] Unknown command code raises unknown error
// [R21] Multi-word program skips all-ones words
// [R22] One command at a time; array reads error
// [R23] Signature preset to all ones per check
module fecs_dev (
  input wire logic i_clk,
  input wire logic i_rstn,
  fecs_bus_if.dev bus,
  output logic o_busy,
  output logic [4:0] o_masked_irq_status
);
  fecs_pkg::fecs_dev_s s_r;
  fecs_pkg::fecs_dev_s s_nxt;
  logic [31:0] mem [0:`FECS_ALL_WORDS-1]; // see [R1]
  // Bulk commands touch a group of lanes per cycle to keep full-array runs short
  logic [`FECS_LANES-1:0] lane_we;
  logic [31:0] lane_wd [`FECS_LANES];
  logic [31:0] lane_rd [`FECS_LANES];
  logic [31:0] eng_word;
  logic [31:0] eng_wdat;
  logic [31:0] bus_word;
  logic addr_phase;
  logic bus_reg;
  logic [7:0] bus_off;
  logic prot;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr_step(input logic [31:0] sig, input logic [31:0] word);
    lfsr_step = {sig[30:0], 1'b0} ^ (sig[31] ? `FECS_SIG_POLY : 32'h00000000) ^ word;
  endfunction

  function automatic logic [15:0] page_base(input logic [15:0] ptr);
    page_base = {ptr[15:9], 9'h000}; // see [R2]
  endfunction

  function automatic logic legal_cmd(input logic [7:0] c);
    legal_cmd = (c == `FECS_CMD_PAGE_ERASE) || (c == `FECS_CMD_CLEAR_ALL) ||
                (c == `FECS_CMD_PROGRAM) || (c == `FECS_CMD_FILL_ALL) ||
                (c == `FECS_CMD_CHECK_ALL) || (c == `FECS_CMD_MULTI);
  endfunction

  // ==========================================================================
  // Bus decode and outputs
  assign addr_phase = bus.hsel && bus.htrans[1] && bus.hready;
  assign bus_reg = bus.haddr[`FECS_REG_SEL_BIT];
  assign bus_off = bus.haddr[7:0];
  assign bus_word = mem[bus.haddr[17:2]]; // see [R2]
  assign prot = s_r.lock && bus.cpu_halted;
  assign eng_word = mem[s_r.cur];
  for (genvar k = 0; k < `FECS_LANES; k++) begin : g_lane
    assign lane_rd[k] = mem[s_r.cur + 16'(k)];
  end
  assign eng_wdat = (s_r.cmd == `FECS_CMD_MULTI) ? s_r.data[s_r.bidx] : s_r.data[0];
  assign bus.hrdata = s_r.rdata;
  // Error is the usual two-cycle answer: wait with error, then ready with error
  assign bus.hready = !s_r.err_a;
  assign bus.hresp = s_r.err_a || s_r.err_b;
  assign bus.ram_dbg_block = s_r.lock; // see [R17]
  assign o_busy = (s_r.st == fecs_pkg::ENG_RUN);
  assign o_masked_irq_status = s_r.raw & s_r.mask;

  // ==========================================================================
  // Sequencer, registers and bus slave
  always_comb begin
    logic [4:0] clr;
    logic [4:0] set;
    logic last;
    logic ok;
    logic [16:0] step;
    clr = 5'h00;
    set = 5'h00;
    last = 1'b0;
    ok = s_r.pass;
    step = 17'h00001;
    s_nxt = s_r;
    lane_we = {`FECS_LANES{1'b0}};
    for (int k = 0; k < `FECS_LANES; k++) begin
      lane_wd[k] = `FECS_ERASED;
    end
    s_nxt.err_a = 1'b0;
    s_nxt.err_b = s_r.err_a;
    s_nxt.dp_valid = addr_phase;
    s_nxt.dp_write = bus.hwrite;
    s_nxt.dp_reg = bus_reg;
    s_nxt.dp_off = bus_off;
    // Lock follows the two top words; a never-written array reads unknown
    s_nxt.lock = (mem[`FECS_LOCK_WORD0] != `FECS_ERASED) ||
                 (mem[`FECS_LOCK_WORD1] != `FECS_ERASED); // see [R18]

    // Engine: bulk commands take a lane group per cycle, programs one word
    if (s_r.st == fecs_pkg::ENG_RUN) begin
      case (s_r.cmd)
        `FECS_CMD_PAGE_ERASE, `FECS_CMD_CLEAR_ALL: begin
          step = `FECS_BULK_STEP;
          for (int k = 0; k < `FECS_LANES; k++) begin
            lane_we[k] = 1'b1; // see [R10] see [R11] see [R3]
          end
        end
        `FECS_CMD_FILL_ALL: begin
          step = `FECS_BULK_STEP;
          for (int k = 0; k < `FECS_LANES; k++) begin
            lane_we[k] = 1'b1;
            lane_wd[k] = lane_rd[k] & s_r.data[0]; // see [R15] see [R3]
          end
        end
        `FECS_CMD_PROGRAM, `FECS_CMD_MULTI: begin
          // Programming ANDs in, so a one can never be restored here
          lane_we[0] = !(s_r.cmd == `FECS_CMD_MULTI && eng_wdat == `FECS_ERASED); // see [R21]
          lane_wd[0] = eng_word & eng_wdat; // see [R3] see [R12] see [R13]
        end
        `FECS_CMD_CHECK_ALL: begin
          step = `FECS_BULK_STEP;
          for (int k = 0; k < `FECS_LANES; k++) begin
            s_nxt.sig = lfsr_step(s_nxt.sig, lane_rd[k]); // see [R7]
            ok = ok && (lane_rd[k] == s_r.data[0]); // see [R6]
          end
          s_nxt.pass = ok;
        end
        default: lane_we[0] = 1'b0;
      endcase
      last = (s_r.left == step);
      s_nxt.cur = s_r.cur + step[15:0];
      s_nxt.bidx = s_r.bidx + 2'h1;
      s_nxt.left = s_r.left - step;
      if (last) begin
        s_nxt.st = fecs_pkg::ENG_IDLE;
        set[`FECS_F_DONE] = 1'b1; // see [R8]
        set[`FECS_F_PASS] = (s_r.cmd == `FECS_CMD_CHECK_ALL) && ok; // see [R6]
      end
    end

    // Data phase of a register write
    if (s_r.dp_valid && s_r.dp_write && s_r.dp_reg) begin
      case (s_r.dp_off)
        `FECS_OFF_COMMAND: begin
          if (s_r.st == fecs_pkg::ENG_RUN) begin
            set[`FECS_F_BUSYERR] = 1'b1; // see [R19] see [R22]
          end else if (!legal_cmd(bus.hwdata[7:0]) || bus.hwdata[31:8] != 24'h000000) begin
            set[`FECS_F_UNKNOWN] = 1'b1; // see [R20]
          end else begin
            s_nxt.st = fecs_pkg::ENG_RUN; // see [R22]
            s_nxt.cmd = bus.hwdata[7:0];
            set[`FECS_F_START] = 1'b1; // see [R8]
            s_nxt.sig = `FECS_SIG_SEED; // see [R23]
            s_nxt.pass = 1'b1;
            s_nxt.bidx = 2'h0;
            case (bus.hwdata[7:0])
              `FECS_CMD_PAGE_ERASE: begin
                s_nxt.cur = page_base(s_r.ptr); // see [R10]
                s_nxt.left = `FECS_PAGE_WORDS;
              end
              `FECS_CMD_PROGRAM: begin
                s_nxt.cur = s_r.ptr; // see [R12]
                s_nxt.left = 17'h00001;
              end
              `FECS_CMD_MULTI: begin
                s_nxt.cur = s_r.ptr; // see [R13]
                s_nxt.left = 17'h00004;
              end
              default: begin
                s_nxt.cur = 16'h0000;
                s_nxt.left = `FECS_ALL_WORDS;
              end
            endcase
          end
        end
        `FECS_OFF_MASKED_IRQ_STATUS, `FECS_OFF_IRQRAW: clr = bus.hwdata[4:0]; // see [R9]
        `FECS_OFF_IRQMASK: s_nxt.mask = bus.hwdata[4:0];
        `FECS_OFF_ADDRESS: s_nxt.ptr = bus.hwdata[15:0];
        `FECS_OFF_BURST_WORD_ZERO: s_nxt.data[0] = bus.hwdata;
        `FECS_OFF_DATA1: s_nxt.data[1] = bus.hwdata;
        `FECS_OFF_DATA2: s_nxt.data[2] = bus.hwdata;
        `FECS_OFF_DATA3: s_nxt.data[3] = bus.hwdata;
        default: clr = 5'h00;
      endcase
    end
    // A hardware event wins over a clear in the same cycle
    s_nxt.raw = (s_r.raw & ~clr) | set; // see [R9]

    // Address phase: prepare read data for the data phase
    s_nxt.rdata = 32'h00000000;
    if (addr_phase && !bus.hwrite) begin
      if (bus_reg) begin
        case (bus_off)
          `FECS_OFF_COMMAND: s_nxt.rdata = {24'h000000, s_r.cmd};
          `FECS_OFF_MASKED_IRQ_STATUS: s_nxt.rdata = {27'h0000000, s_r.raw & s_r.mask};
          `FECS_OFF_IRQMASK: s_nxt.rdata = {27'h0000000, s_r.mask};
          `FECS_OFF_IRQRAW: s_nxt.rdata = {27'h0000000, s_r.raw};
          `FECS_OFF_SIZE: s_nxt.rdata = {16'h0000, `FECS_LAST_WORD};
          `FECS_OFF_ADDRESS: s_nxt.rdata = {16'h0000, s_r.ptr};
          `FECS_OFF_SIGNATURE: s_nxt.rdata = s_r.sig; // see [R7]
          `FECS_OFF_BURST_WORD_ZERO: s_nxt.rdata = s_r.data[0];
          `FECS_OFF_DATA1: s_nxt.rdata = s_r.data[1];
          `FECS_OFF_DATA2: s_nxt.rdata = s_r.data[2];
          `FECS_OFF_DATA3: s_nxt.rdata = s_r.data[3];
          default: s_nxt.rdata = 32'h00000000;
        endcase
      end else if (s_r.st == fecs_pkg::ENG_RUN) begin
        s_nxt.err_a = 1'b1; // see [R22]
      end else if (prot) begin
        s_nxt.err_a = bus.dbg_access; // see [R16]
      end else begin
        s_nxt.rdata = bus_word; // see [R5]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.ptr <= 16'h0000;
      s_r.data <= {4{`FECS_ERASED}};
      s_r.mask <= `FECS_MASK_RST;
      s_r.sig <= `FECS_SIG_SEED;
      // Locked until the top words have been looked at
      s_r.lock <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array storage has no reset, as a real flash keeps its content
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < `FECS_LANES; k++) begin
      if (lane_we[k]) begin
        mem[s_r.cur + 16'(k)] <= lane_wd[k];
      end
    end
  end
endmodule

// ### fecs_monitor.sv
// Protocol checker on the word bus between the host and the flash sequencer
`timescale 1ns/10ps
module fecs_monitor (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic hresp,
  input wire logic dbg_access,
  input wire logic cpu_halted,
  input wire logic ram_dbg_block,
  input wire logic o_busy
);
  logic rd_arr;
  logic take_wr;
  logic locked;
  assign rd_arr = hsel && htrans[1] && hready && !hwrite && !haddr[28];
  assign take_wr = hsel && htrans[1] && hready && hwrite;
  assign locked = ram_dbg_block && cpu_halted;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // ==========================================================================
  // Error response shape
  a_err_two_cycle: assert property (hresp && !hready |=> hresp && hready)
    else $error("error response not two cycles long");
  a_err_onset: assert property ($rose(hresp) |-> !hready && $past(rd_arr))
    else $error("error response without an array read");
  // ==========================================================================
  // Array reads and write answers
  a_busy_read_err: assert property (rd_arr && o_busy |=> hresp && !hready)
    else $error("array read while busy not refused");
  a_lock_dbg_err: assert property (rd_arr && locked && dbg_access |=> hresp)
    else $error("locked debug read without error");
  a_lock_zero: assert property (rd_arr && locked |=> hrdata == 32'h0)
    else $error("locked read returned data");
  a_lock_cpu_ok: assert property (rd_arr && locked && !dbg_access && !o_busy |=> !hresp)
    else $error("locked processor read got an error");
  a_plain_read_ok: assert property (rd_arr && !locked && !o_busy |=> !hresp && hready)
    else $error("plain array read refused");
  a_write_okay: assert property (take_wr |=> !hresp && hrdata == 32'h0)
    else $error("write answered with error or data");
endmodule

// ### embedded_flash_command_sequencer_tb.sv
// Testbench joining the host and sequencer ends over the word bus
`timescale 1ns/10ps
module embedded_flash_command_sequencer_tb;
  typedef struct {logic [15:0] p; logic [31:0] d; logic [31:0] x;} fecs_row_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic halted = 1'b0;
  logic [31:0] rdata, q;
  logic blocked, busy, e;
  logic [4:0] irq;
  logic [31:0] mem [0:65535];
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Second program of word 0 may only clear further bits
  fecs_row_s rows [5] = '{'{16'h0000, 32'hF0F0FFFF, 32'hF0F0FFFF},
    '{16'h0000, 32'hFF00FF00, 32'hF000FF00}, '{16'h01FF, 32'h0, 32'h0},
    '{16'h0240, 32'h5A5A5A5A, 32'h5A5A5A5A}, '{16'hFFFD, 32'hA5A50000, 32'hA5A50000}};
  logic [39:0] regs [6] = '{40'h0C0000001F, 40'h140000FFFF, 40'h24FFFFFFFF,
    40'h40FFFFFFFF, 40'h4CFFFFFFFF, 40'h3000000000};
  logic [31:0] bw [4] = '{32'h12345678, 32'hFFFFFFFF, 32'h000000AA, 32'h87654321};
  logic [15:0] pk [4] = '{16'h01FF, 16'h0200, 16'h0244, 16'h0400};
  fecs_bus_if bus ();
  fecs_host i_fecs_host (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cpu_halted(halted),
    .o_ram_dbg_blocked(blocked), .bus(bus));
  fecs_dev i_fecs_dev (.i_clk(clk), .i_rstn(rstn), .bus(bus), .o_busy(busy),
    .o_masked_irq_status(irq));
  fecs_monitor i_fecs_monitor (.i_clk(clk), .i_rstn(rstn), .hsel(bus.hsel),
    .haddr(bus.haddr), .htrans(bus.htrans), .hwrite(bus.hwrite), .hrdata(bus.hrdata),
    .hready(bus.hready), .hresp(bus.hresp), .dbg_access(bus.dbg_access),
    .cpu_halted(bus.cpu_halted), .ram_dbg_block(bus.ram_dbg_block), .o_busy(busy));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==========================================================================
  // Checking and bus tasks
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bounded so a stuck sequencer still reaches the report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    num_checks++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic hw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic hr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One host transfer: address, data, go; wait for done, fetch data, clear done
  task automatic xf(input logic [31:0] a, input logic [31:0] d, input logic [2:0] c);
    logic [31:0] s;
    hw(8'h00, a);
    hw(8'h04, d);
    hw(8'h08, {29'h0, c});
    for (int i = 0; i < 20; i++) begin
      hr(8'h0C, s);
      if (s[2] === 1'b1) break;
    end
    chk("host done", 32'h1, {31'h0, s[2]});
    hr(8'h10, q);
    e = s[1];
    hw(8'h0C, 32'h4);
  endtask
  task automatic dw(input logic [7:0] o, input logic [31:0] d);
    xf({24'h100000, o}, d, 3'h3);
  endtask
  task automatic drd(input logic [7:0] o);
    xf({24'h100000, o}, 32'h0, 3'h1);
  endtask
  task automatic arr(input logic [15:0] w, input logic dbg);
    xf({14'h0, w, 2'h0}, 32'h0, {dbg, 2'h1});
  endtask
  task automatic cmd(input logic [7:0] c, input logic [4:0] x);
    dw(8'h00, {24'h0, c});
    for (int i = 0; i < 70000 && busy === 1'b1; i++) @(posedge clk);
    drd(8'h10);
    chk("raw flags", {27'h0, x}, q);
    dw(8'h08, 32'h1F);
    drd(8'h10);
    chk("cleared flags", 32'h0, q);
  endtask
  task automatic prog(input logic [15:0] p, input logic [31:0] d);
    dw(8'h18, {16'h0, p});
    dw(8'h40, d);
    cmd(8'h33, 5'h03);
    mem[p] = mem[p] & d;
  endtask
  task automatic fill(input int lo, input int hi);
    for (int k = lo; k <= hi; k++) mem[k] = 32'hFFFFFFFF;
  endtask
  function automatic logic [31:0] sig_of();
    logic [31:0] s;
    s = 32'hFFFFFFFF;
    for (int i = 0; i < 65536; i++) s = {s[30:0], 1'b0} ^ (s[31] ? 32'h8000001B : 32'h0) ^ mem[i];
    return s;
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i]) begin
      drd(regs[i][39:32]);
      chk("reset register", regs[i][31:0], q);
    end
    cmd(8'h22, 5'h03);
    // Fill over an erased array leaves one value everywhere, so the compare must pass
    dw(8'h40, 32'h5AA5C33C);
    cmd(8'h44, 5'h03);
    foreach (mem[k]) mem[k] = 32'h5AA5C33C;
    chk("lock by fill", 32'h1, {31'h0, blocked});
    cmd(8'h55, 5'h13);
    drd(8'h24);
    chk("uniform signature", sig_of(), q);
    cmd(8'h22, 5'h03);
    fill(0, 65535);
    chk("lock clear", 32'h0, {31'h0, blocked});
    foreach (rows[i]) begin
      prog(rows[i].p, rows[i].d);
      arr(rows[i].p, 1'b0);
      chk("array word", rows[i].x, q);
    end
    dw(8'h18, 32'h0241);
    foreach (bw[i]) dw(8'h40 + 8'(4 * i), bw[i]);
    cmd(8'hCC, 5'h03);
    foreach (bw[i]) mem[16'h0241 + i] = mem[16'h0241 + i] & bw[i];
    for (int k = 16'h0240; k < 16'h0246; k++) begin
      arr(k[15:0], 1'b0);
      chk("burst word", mem[k], q);
    end
    dw(8'h18, 32'h0200);
    cmd(8'h11, 5'h03);
    fill(16'h0200, 16'h03FF);
    foreach (pk[i]) begin
      arr(pk[i], 1'b0);
      chk("after page erase", mem[pk[i]], q);
    end
    dw(8'h18, 32'h0400);
    dw(8'h00, 32'h11);
    arr(16'h0400, 1'b0);
    chk("busy read error", 32'h1, {31'h0, e});
    chk("busy read data", 32'h0, q);
    dw(8'h00, 32'h33);
    for (int i = 0; i < 1000 && busy === 1'b1; i++) @(posedge clk);
    drd(8'h10);
    chk("busy error flag", 32'h07, q);
    dw(8'h10, 32'h1F);
    dw(8'h00, 32'h77);
    drd(8'h10);
    chk("unknown flag", 32'h08, q);
    chk("busy after unknown", 32'h0, {31'h0, busy});
    dw(8'h0C, 32'h17);
    chk("masked status", 32'h0, {27'h0, irq});
    drd(8'h08);
    chk("masked read", 32'h0, q);
    dw(8'h0C, 32'h1F);
    chk("unmasked status", 32'h08, {27'h0, irq});
    dw(8'h08, 32'h1F);
    prog(16'hFFFE, 32'h12345678);
    chk("lock set", 32'h1, {31'h0, blocked});
    halted <= 1'b1;
    arr(16'h0000, 1'b0);
    chk("locked cpu read", {32'h0}, q);
    chk("locked cpu resp", 32'h0, {31'h0, e});
    arr(16'h0000, 1'b1);
    chk("locked debug read", 32'h0, q);
    chk("locked debug resp", 32'h1, {31'h0, e});
    halted <= 1'b0;
    arr(16'h0000, 1'b0);
    chk("running read", mem[0], q);
    dw(8'h18, 32'hFE00);
    cmd(8'h11, 5'h03);
    fill(16'hFE00, 16'hFFFF);
    chk("lock released", 32'h0, {31'h0, blocked});
    // Array holds mixed words, so the compare must fail and only the signature speaks
    dw(8'h40, 32'hFFFFFFFF);
    cmd(8'h55, 5'h03);
    drd(8'h24);
    chk("signature", sig_of(), q);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    drd(8'h0C);
    chk("mask after reset", 32'h1F, q);
    arr(16'h0000, 1'b0);
    chk("array kept", mem[0], q);
    finish_test();
  end
endmodule
